// ===== core/sdr_pkg.sv
// constants shared by the serial data register block and its link partner
package sdr_pkg;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_DATA = 8'h0c;
  localparam int         CB_RATE   = 0;
  localparam int         CB_CLOCK_PHASE_BIT   = 2;
  localparam int         CB_SEL    = 3;
  localparam int         CB_MASTER_SELECT_BIT   = 4;
  localparam int         CB_EN     = 6;
  localparam int         CB_IE     = 7;
  localparam int         SB_DONE   = 7;
  localparam int         SB_WRITE_COLLISION_FLAG   = 6;
  localparam int         SB_FAULT  = 4;
  localparam logic       SEL_RST   = 1'b1;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [7:0] BUF_RST   = 8'h00;
  localparam int         CLK_NS    = 5;
  localparam int         DEV_HALF_NS = 80;
  localparam int         PTN_HALF_NS = 80;
  localparam logic [7:0] DEV_HALF  = 8'((DEV_HALF_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] PTN_HALF  = 8'((PTN_HALF_NS + CLK_NS - 1) / CLK_NS);
endpackage

// ===== core/sdr_link_if.sv
// serial link wires between the device end and its partner end
interface sdr_link_if;
  logic dSckO, dSckOe, dMosiO, dMosiOe, dMisoO, dMisoOe, dSelN;
  logic pSckO, pSckOe, pMosiO, pMosiOe, pMisoO, pMisoOe, pSsO, pSsOe;
  logic sck, mosi, miso, devSsN;
  assign sck    = dSckOe ? dSckO : (pSckOe ? pSckO : 1'b0);
  assign mosi   = dMosiOe ? dMosiO : (pMosiOe ? pMosiO : 1'b0);
  assign miso   = dMisoOe ? dMisoO : (pMisoOe ? pMisoO : 1'b0);
  assign devSsN = pSsOe ? pSsO : 1'b1;
  modport dev (
    output dSckO, dSckOe, dMosiO, dMosiOe, dMisoO, dMisoOe, dSelN,
    input  sck, mosi, miso, devSsN
  );
  modport ptn (
    output pSckO, pSckOe, pMosiO, pMosiOe, pMisoO, pMisoOe, pSsO, pSsOe,
    input  sck, mosi, miso, dSelN
  );
endinterface

// ===== core/sdr_spi_dev.sv
// serial data register unit with apb register access
module sdr_spi_dev (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  sdr_link_if.dev          io
);
  import sdr_pkg::*;

  typedef struct packed {
    logic       ie;
    logic       en;
    logic       master_select_bit;
    logic       clock_phase_bit;
    logic       selN;
    logic [1:0] rate;
    logic       done;
    logic       write_collision_flag;
    logic       fault;
    logic       stsArm;
    logic [7:0] shift;
    logic [7:0] rxBuf;
    logic [7:0] rdData;
    logic [3:0] cnt;
    logic       busy;
    logic       sckO;
    logic       outBit;
    logic       inBit;
    logic [7:0] div;
    logic [2:0] sckS;
    logic [2:0] ssS;
    logic [2:0] rxS;
    logic       sckF;
    logic       ssF;
    logic       rxF;
  } sdr_dev_t;

  sdr_dev_t   s;
  sdr_dev_t   nx;
  logic       lead;
  logic       trail;
  logic       setup;
  logic       acc;
  logic [7:0] half;
  logic       inBitNow;

  function automatic logic sdrHit(input logic [7:0] a);
    return (a == ADDR_CTRL) || (a == ADDR_STAT) || (a == ADDR_DATA);
  endfunction

  function automatic logic [7:0] ctrlWord(input sdr_dev_t r);
    logic [7:0] w;
    w = 8'h00;
    w[CB_RATE +: 2] = r.rate;
    w[CB_CLOCK_PHASE_BIT]      = r.clock_phase_bit;
    w[CB_SEL]       = r.selN;
    w[CB_MASTER_SELECT_BIT]      = r.master_select_bit;
    w[CB_EN]        = r.en;
    w[CB_IE]        = r.ie;
    return w;
  endfunction

  function automatic logic [7:0] statWord(input sdr_dev_t r);
    logic [7:0] w;
    w = 8'h00;
    w[SB_DONE]  = r.done;
    w[SB_WRITE_COLLISION_FLAG]  = r.write_collision_flag;
    w[SB_FAULT] = r.fault;
    return w;
  endfunction

  assign setup    = psel && !penable;
  assign acc      = psel && penable;
  assign half     = 8'(DEV_HALF << s.rate);
  assign inBitNow = s.clock_phase_bit ? s.rxF : s.inBit;

  always_comb begin
    nx    = s;
    lead  = 1'b0;
    trail = 1'b0;
    // three-stage input sampling, change taken when stages two and three agree
    nx.sckS = {s.sckS[1:0], io.sck};
    nx.ssS  = {s.ssS[1:0], io.devSsN};
    nx.rxS  = {s.rxS[1:0], (s.master_select_bit ? io.miso : io.mosi)};
    if (s.sckS[1] == s.sckS[2]) begin
      nx.sckF = s.sckS[2];
    end
    if (s.ssS[1] == s.ssS[2]) begin
      nx.ssF = s.ssS[2];
    end
    if (s.rxS[1] == s.rxS[2]) begin
      nx.rxF = s.rxS[2];
    end
    // read data captured in setup phase
    if (setup) begin
      unique case (paddr)
        ADDR_CTRL: nx.rdData = ctrlWord(s);
        ADDR_STAT: nx.rdData = statWord(s);
        ADDR_DATA: nx.rdData = s.rxBuf;
        default:   nx.rdData = 8'h00;
      endcase
    end
    // register side effects in access phase
    if (acc) begin
      unique case (paddr)
        ADDR_CTRL: begin
          if (pwrite) begin
            nx.ie   = pwdata[CB_IE];
            nx.clock_phase_bit = pwdata[CB_CLOCK_PHASE_BIT];
            nx.selN = pwdata[CB_SEL];
            nx.rate = pwdata[CB_RATE +: 2];
            if (!s.fault || s.stsArm) begin
              nx.en    = pwdata[CB_EN];
              nx.master_select_bit  = pwdata[CB_MASTER_SELECT_BIT];
              nx.fault = 1'b0;
              if (s.fault) begin
                nx.stsArm = 1'b0;
              end
            end
          end
        end
        ADDR_STAT: begin
          if (!pwrite) begin
            nx.stsArm = s.done || s.write_collision_flag || s.fault;
          end
        end
        ADDR_DATA: begin
          if (s.stsArm) begin
            nx.done   = 1'b0;
            nx.write_collision_flag   = 1'b0;
            nx.stsArm = 1'b0;
          end
          if (pwrite) begin
            if (s.busy) begin
              nx.write_collision_flag = 1'b1;
            end else if (!s.done || s.stsArm) begin
              nx.shift = pwdata[7:0];
              if (s.en && s.master_select_bit) begin
                nx.busy = 1'b1;
                nx.div  = 8'h00;
                nx.cnt  = 4'h0;
              end
            end
          end
        end
        default: ;
      endcase
    end
    // master clock generation
    if (s.busy && s.master_select_bit) begin
      if (s.div == half - 8'd1) begin
        nx.div  = 8'h00;
        nx.sckO = !s.sckO;
        lead    = !s.sckO;
        trail   = s.sckO;
      end else begin
        nx.div = s.div + 8'd1;
      end
    end
    // slave follows received clock only while selected
    if (s.en && !s.master_select_bit) begin
      if (s.ssF) begin
        nx.cnt  = 4'h0;
        nx.busy = 1'b0;
      end else begin
        lead  = !s.sckF && nx.sckF;
        trail = s.sckF && !nx.sckF;
        if (!s.clock_phase_bit) begin
          nx.busy = 1'b1;
        end
      end
    end
    if (lead) begin
      if (s.clock_phase_bit) begin
        nx.outBit = s.shift[7];
      end else begin
        nx.inBit = s.rxF;
      end
      if (!s.master_select_bit) begin
        nx.busy = 1'b1;
      end
    end
    if (trail) begin
      nx.shift = {s.shift[6:0], inBitNow};
      nx.cnt   = s.cnt + 4'd1;
      if (s.cnt == 4'd7) begin
        nx.cnt  = 4'h0;
        nx.done = 1'b1;
        if (s.master_select_bit || s.clock_phase_bit) begin
          nx.busy = 1'b0;
        end
        if (!s.done) begin
          nx.rxBuf = {s.shift[6:0], inBitNow};
        end
      end
    end
    // mode fault on slave select input pulled low in master mode
    if (s.en && s.master_select_bit && !s.ssF) begin
      nx.fault = 1'b1;
      nx.en    = 1'b0;
      nx.master_select_bit  = 1'b0;
      nx.busy  = 1'b0;
      nx.sckO  = 1'b0;
      nx.cnt   = 4'h0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s       <= '0;
      s.selN  <= SEL_RST;
      s.shift <= SHIFT_RST;
      s.rxBuf <= BUF_RST;
      s.ssS   <= 3'b111;
      s.ssF   <= 1'b1;
    end else begin
      s <= nx;
    end
  end

  assign prdata     = {24'h00_0000, s.rdData};
  assign pready     = acc;
  assign pslverr    = acc && !sdrHit(paddr);
  assign irq        = s.ie && (s.done || s.fault);
  assign io.dSckO   = s.sckO;
  assign io.dSckOe  = s.en && s.master_select_bit;
  assign io.dMosiO  = s.clock_phase_bit ? s.outBit : s.shift[7];
  assign io.dMosiOe = s.en && s.master_select_bit;
  assign io.dMisoO  = s.clock_phase_bit ? s.outBit : s.shift[7];
  assign io.dMisoOe = s.en && !s.master_select_bit && !s.ssF;
  assign io.dSelN   = s.selN;
endmodule

// ===== core/sdr_spi_ptn.sv
// partner end: external master or slave on the serial link
module sdr_spi_ptn #(
  parameter logic [7:0] HALF = sdr_pkg::PTN_HALF
) (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       isMaster,
  input  wire logic       clock_phase_bit,
  input  wire logic [7:0] txByte,
  input  wire logic       txLoad,
  output logic      [7:0] rxByte,
  output logic            rxDone,
  output logic            busy,
  sdr_link_if.ptn         io
);
  import sdr_pkg::*;

  typedef struct packed {
    logic [7:0] shift;
    logic [7:0] rxByte;
    logic       done;
    logic       busy;
    logic [1:0] gap;
    logic       sckO;
    logic       ssO;
    logic       outBit;
    logic       inBit;
    logic [3:0] cnt;
    logic [7:0] div;
    logic [2:0] sckS;
    logic [2:0] selS;
    logic [2:0] rxS;
    logic       sckF;
    logic       selF;
    logic       rxF;
  } sdr_ptn_t;

  sdr_ptn_t s;
  sdr_ptn_t nx;
  logic     lead;
  logic     trail;
  logic     inBitNow;

  assign inBitNow = clock_phase_bit ? s.rxF : s.inBit;

  always_comb begin
    nx      = s;
    lead    = 1'b0;
    trail   = 1'b0;
    nx.done = 1'b0;
    nx.sckS = {s.sckS[1:0], io.sck};
    nx.selS = {s.selS[1:0], io.dSelN};
    nx.rxS  = {s.rxS[1:0], (isMaster ? io.miso : io.mosi)};
    if (s.sckS[1] == s.sckS[2]) begin
      nx.sckF = s.sckS[2];
    end
    if (s.selS[1] == s.selS[2]) begin
      nx.selF = s.selS[2];
    end
    if (s.rxS[1] == s.rxS[2]) begin
      nx.rxF = s.rxS[2];
    end
    if (txLoad && !s.busy) begin
      nx.shift = txByte;
      if (isMaster) begin
        nx.busy = 1'b1;
        nx.ssO  = 1'b0;
        nx.div  = 8'h00;
        nx.cnt  = 4'h0;
        nx.gap  = 2'd0;
      end
    end
    if (s.busy && isMaster) begin
      if (s.div == HALF - 8'd1) begin
        nx.div = 8'h00;
        if (s.gap == 2'd1) begin
          nx.ssO = 1'b1;
          nx.gap = 2'd2;
        end else if (s.gap == 2'd2) begin
          nx.busy = 1'b0;
          nx.gap  = 2'd0;
        end else begin
          nx.sckO = !s.sckO;
          lead    = !s.sckO;
          trail   = s.sckO;
        end
      end else begin
        nx.div = s.div + 8'd1;
      end
    end
    if (!isMaster) begin
      if (s.selF) begin
        nx.cnt = 4'h0;
      end else begin
        lead  = !s.sckF && nx.sckF;
        trail = s.sckF && !nx.sckF;
      end
    end
    if (lead) begin
      if (clock_phase_bit) begin
        nx.outBit = s.shift[7];
      end else begin
        nx.inBit = s.rxF;
      end
    end
    if (trail) begin
      nx.shift = {s.shift[6:0], inBitNow};
      nx.cnt   = s.cnt + 4'd1;
      if (s.cnt == 4'd7) begin
        nx.cnt    = 4'h0;
        nx.done   = 1'b1;
        nx.rxByte = {s.shift[6:0], inBitNow};
        if (isMaster) begin
          nx.gap = 2'd1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s      <= '0;
      s.ssO  <= 1'b1;
      s.selS <= 3'b111;
      s.selF <= 1'b1;
    end else begin
      s <= nx;
    end
  end

  assign rxByte     = s.rxByte;
  assign rxDone     = s.done;
  assign busy       = s.busy;
  assign io.pSckO   = s.sckO;
  assign io.pSckOe  = isMaster;
  assign io.pMosiO  = clock_phase_bit ? s.outBit : s.shift[7];
  assign io.pMosiOe = isMaster;
  assign io.pMisoO  = clock_phase_bit ? s.outBit : s.shift[7];
  assign io.pMisoOe = !isMaster && !s.selF;
  assign io.pSsO    = s.ssO;
  assign io.pSsOe   = isMaster;
endmodule

// ===== verif/sdr_link_props.sv
// link checker for the serial data register ends
module sdr_link_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic dSckOe,
  input wire logic dMosiOe,
  input wire logic dMisoOe,
  input wire logic dSelN,
  input wire logic pSckOe,
  input wire logic pMosiOe,
  input wire logic pMisoOe,
  input wire logic sck,
  input wire logic devSsN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] rises;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // rising clock edges within one device selection
  always_ff @(posedge sys_clk)
    if (srst || devSsN) rises <= 4'h0;
    else if ($rose(sck)) rises <= rises + 4'h1;
  sck_yield_a: assert property (dSckOe && !devSsN |-> ##[1:6] !dSckOe)
    else $error("device kept the link clock against another master");
  miso_single_a: assert property (!(dMisoOe && pMisoOe))
    else $error("two ends drive miso");
  ptn_miso_sel_a: assert property (dSelN [*5] |-> !pMisoOe)
    else $error("partner drives miso while deselected");
  dev_miso_sel_a: assert property (devSsN [*8] |-> !dMisoOe)
    else $error("device drives miso while deselected");
  dev_mosi_own_a: assert property (dMosiOe |-> dSckOe)
    else $error("device drives mosi without owning the clock");
  ptn_mosi_own_a: assert property (pMosiOe |-> pSckOe && !pMisoOe)
    else $error("partner drives mosi without being master");
  sck_high_a: assert property ($rose(sck) |-> sck [*8])
    else $error("link clock high phase too short");
  sck_low_a: assert property ($fell(sck) |-> !sck [*8])
    else $error("link clock low phase too short");
  frame_len_a: assert property (rises <= 4'h8)
    else $error("more than one byte in one selection");
endmodule

// ===== verif/spi_data_register_transfer_tb.sv
// self-checking bench for both ends of the serial data register link
module spi_data_register_transfer_tb
  import sdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00, txByte = 8'h00, rxByte, d, pa, pb;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, irq, rxDone, busy, isMaster = 1'b0, clock_phase_bit = 1'b0, txLoad = 1'b0;
  logic [32:0] rdQ[$];
  logic [7:0]  rxQ[$];
  int          fails = 0, nCompared = 0, seed = 42281;
  sdr_link_if link ();
  always #2.5 sys_clk = ~sys_clk;
  sdr_spi_dev sdr_spi_dev_inst (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .io(link));
  sdr_spi_ptn sdr_spi_ptn_inst (.sys_clk(sys_clk), .srst(srst), .isMaster(isMaster),
    .clock_phase_bit(clock_phase_bit), .txByte(txByte), .txLoad(txLoad), .rxByte(rxByte), .rxDone(rxDone),
    .busy(busy), .io(link));
  sdr_link_props sdr_link_props_inst (.sys_clk(sys_clk), .srst(srst), .dSckOe(link.dSckOe),
    .dMosiOe(link.dMosiOe), .dMisoOe(link.dMisoOe), .dSelN(link.dSelN), .pSckOe(link.pSckOe),
    .pMosiOe(link.pMosiOe), .pMisoOe(link.pMisoOe), .sck(link.sck), .devSsN(link.devSsN));
  task automatic cmp(input string nm, input logic [32:0] e, input logic [32:0] s);
    nCompared++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test();
    if (fails == 0 && nCompared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // w low: wait partner idle, w high: wait interrupt
  task automatic wt(input logic w);
    int n;
    n = 0;
    while ((w ? irq : busy) !== w) begin
      @(posedge sys_clk);
      if (++n > 3000) begin
        fails++;
        end_of_test();
      end
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] dt);
    int n;
    n = 0;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= 32'(dt);
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (++n > 50) begin
        fails++;
        end_of_test();
      end
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic err = 1'b0);
    rdQ.push_back({err, 24'h00_0000, e});
    apb(a, 1'b0, 8'h00);
  endtask
  task automatic ptx(input logic [7:0] b);
    txByte <= b;
    txLoad <= 1'b1;
    @(posedge sys_clk);
    txLoad <= 1'b0;
    @(posedge sys_clk);
    wt(1'b0);
  endtask
  // result watcher
  always @(posedge sys_clk) begin
    if (psel && penable && pready && !pwrite) begin
      cmp("apb read", rdQ.pop_front(), {pslverr, prdata});
    end
    if (rxDone === 1'b1) begin
      cmp("partner byte", 33'(rxQ.pop_front()), 33'(rxByte));
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(ADDR_STAT, 8'h00);
    rd(8'h10, 8'h00, 1'b1);
    d = 8'($random(seed));
    pa = 8'($random(seed));
    apb(ADDR_CTRL, 1'b1, 8'hD1);
    ptx(pa);
    rxQ.push_back(d);
    apb(ADDR_DATA, 1'b1, d);
    apb(ADDR_DATA, 1'b1, ~d);
    rd(ADDR_DATA, 8'h00);
    wt(1'b1);
    rd(ADDR_STAT, 8'hC0);
    rd(ADDR_DATA, pa);
    rd(ADDR_STAT, 8'h00);
    cmp("irq", 33'h0_0000_0000, 33'(irq));
    for (int c = 0; c < 2; c++) begin
      apb(ADDR_CTRL, 1'b1, 8'h48 | 8'(c << 2));
      isMaster <= 1'b1;
      clock_phase_bit <= c[0];
      d = 8'($random(seed));
      pa = 8'($random(seed));
      pb = 8'($random(seed));
      apb(ADDR_DATA, 1'b1, d);
      repeat (40) @(posedge sys_clk);
      rd(ADDR_STAT, 8'h00);
      rxQ.push_back(d);
      rxQ.push_back(pa);
      ptx(pa);
      ptx(pb);
      repeat (8) @(posedge sys_clk);
      rd(ADDR_STAT, 8'h80);
      rd(ADDR_DATA, pa);
      rd(ADDR_STAT, 8'h00);
    end
    apb(ADDR_CTRL, 1'b1, 8'hD0);
    rxQ.push_back(8'h00);
    ptx(8'($random(seed)));
    rd(ADDR_CTRL, 8'h80);
    cmp("irq", 33'h0_0000_0001, 33'(irq));
    rd(ADDR_STAT, 8'h10);
    apb(ADDR_CTRL, 1'b1, 8'h00);
    rd(ADDR_STAT, 8'h00);
    end_of_test();
  end
endmodule
